// >>> ncocd_pkg.sv
// package for the nco clock divider and switch block
// assumes one clock domain (mclk) and plain-port control bits
package ncocd_pkg;
    localparam int PDIV_W   = 5;         // prescaler divisor width
    localparam int NDIV_W   = 7;         // feedback divisor width
    localparam int LEN_W    = 3;         // sequence length minus one width
    localparam int PAT_W    = 8;         // divide pattern width
    localparam int CNT_W    = 8;         // period counter width
    localparam logic [3:0] XDIV_LAST = 4'h8;  // crystal divide by nine, count 0..8
    localparam logic [1:0] FS_NEEDED = 2'h2;  // frame syncs to wait after last divider write
    // switch sequencer states
    typedef enum logic [3:0] {
        NCOCD_XTAL = 4'h1,
        NCOCD_WAIT = 4'h2,
        NCOCD_GAP  = 4'h4,
        NCOCD_PLL  = 4'h8
    } ncocd_sel_e;
endpackage

// >>> ncocd_nco_if.sv
// interface carrying settings and ticks between top and one nco divider
// assumes both ends are clocked by mclk
`timescale 1ns/10ps
interface ncocd_nco_if;
    logic [6:0] divisor;   // integer divisor
    logic [2:0] seq_len;   // sequence length minus one
    logic [7:0] pattern;   // divide pattern
    logic       restart;   // pattern restart on parameter write
    logic       in_tick;   // input clock enable
    logic       out_tick;  // one pulse per output period
    modport ctl (output divisor, seq_len, pattern, restart, in_tick, input out_tick);
    modport nco (input divisor, seq_len, pattern, restart, in_tick, output out_tick);
endinterface

// >>> ncocd_nco.sv
// fractional nco divider: divides in_tick by divisor or divisor+1 per pattern bit
// assumes in_tick is a one-cycle enable on mclk
`timescale 1ns/10ps
module ncocd_nco (
    input  wire logic mclk,      // system clock
    input  wire logic rstn,      // async reset, active low
    ncocd_nco_if.nco  bus        // settings and ticks
);
    typedef struct packed {
        logic [ncocd_pkg::CNT_W-1:0] cnt;   // counts input ticks in a period
        logic [ncocd_pkg::LEN_W-1:0] pos;   // current pattern position
        logic                        tick;  // output period pulse
    } ncocd_nco_s;

    ncocd_nco_s r;
    ncocd_nco_s next_r;
    logic [ncocd_pkg::CNT_W-1:0] target;

    // divisor plus the chosen pattern bit; a zero length ignores the pattern
    always_comb begin
        target = {1'b0, bus.divisor};                                 // RULE2
        if (bus.seq_len != 3'h0 && bus.pattern[r.pos]) begin        // RULE4
            target = target + 8'h01;                                  // RULE2
        end
    end

    // count input ticks; at period end step the pattern from top used bit down to zero
    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        if (bus.restart) begin
            next_r.cnt = '0;                                          // RULE17
            next_r.pos = bus.seq_len;                                 // RULE17
        end else if (bus.in_tick) begin
            if (r.cnt + 8'h01 >= target) begin
                next_r.cnt  = '0;
                next_r.tick = 1'b1;                                   // RULE6
                // wrap after bit zero back to length field: period is length plus one
                next_r.pos  = (r.pos == 3'h0) ? bus.seq_len : r.pos - 3'h1; // RULE3 RULE16
            end else begin
                next_r.cnt = r.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign bus.out_tick = r.tick;
endmodule

// >>> ncocd_top.sv
// Summary of operation
// RULE1 - prescaler takes 5-bit divisor, 3-bit length-minus-one, 8-bit pattern
// RULE2 - pattern bit 0 divides by divisor, bit 1 by divisor plus one
// RULE3 - pattern repeats every length-plus-one periods, averaging the ratios
// RULE4 - zero length makes a plain integer divider ignoring the pattern
// RULE5 - feedback divider takes 7-bit divisor, 3-bit length, 8-bit pattern
// RULE6 - feedback divider uses the same fractional pattern mechanism
// RULE7 - host sets feedback so vco equals 2 x 2304 x sample rate
// RULE8 - high pump current after new settings until lock or force-vco
// RULE9 - pll settles within one frame sync period after new settings
// RULE10 - host writes divider registers 08h through 0Dh, 0Dh last
// RULE11 - write of 0Eh commands the switch to the pll clock
// RULE12 - after reset system clock is crystal divided by nine
// RULE13 - switch not before second frame sync after the 0Dh write
// RULE14 - switch to pll clock happens without runt pulse or glitch
// RULE15 - host keeps prescaler output between 2 and 4 MHz
// RULE16 - only low length-plus-one pattern bits, highest first then wrap
// RULE17 - pattern position restarts whenever parameters are rewritten
//
// top of the nco clock divider and clock switch; register bits arrive as plain ports
// assumes xtal and vco edges arrive as pins, sampled here into mclk enables
`timescale 1ns/10ps
module ncocd_top (
    input  wire logic       mclk,          // system clock, 20 MHz
    input  wire logic       rstn,          // async reset, active low
    input  wire logic       xtal_clk_pin,  // crystal clock level from pin
    input  wire logic       vco_clk_pin,   // vco clock level from pin
    input  wire logic [4:0] pre_divisor,   // prescaler integer divisor
    input  wire logic [2:0] pre_seq_len,   // prescaler length minus one
    input  wire logic [7:0] pre_pattern,   // prescaler pattern
    input  wire logic [6:0] fb_divisor,    // feedback integer divisor
    input  wire logic [2:0] fb_seq_len,    // feedback length minus one
    input  wire logic [7:0] fb_pattern,    // feedback pattern
    input  wire logic       div_write,     // any divider register written, pulse
    input  wire logic       last_write,    // 0Dh written, pulse
    input  wire logic       switch_write,  // 0Eh written, pulse
    input  wire logic       frame_sync,    // frame sync start, pulse
    input  wire logic       pll_lock_indicator, // lock detect from pin
    input  wire logic       force_vco,     // force-vco control bit
    output logic            ref_tick,      // prescaler output period pulse
    output logic            fb_tick,       // feedback divider output pulse
    output logic            pump_high,     // charge pump high current
    output logic            sys_tick,      // system clock enable pulse
    output logic            sys_on_pll     // system clock taken from pll
);
    typedef struct packed {
        logic [1:0]                  xs;       // crystal sync pair
        logic [1:0]                  vs;       // vco sync pair
        logic [1:0]                  ls;       // lock sync pair
        logic                        xprev;    // last synced crystal level
        logic                        vprev;    // last synced vco level
        logic [3:0]                  xcnt;     // divide-by-nine counter
        logic                        pump;     // high pump current flag
        ncocd_pkg::ncocd_sel_e       st;       // switch sequencer
        logic [1:0]                  fs_cnt;   // frame syncs since 0Dh
        logic                        sw_req;   // switch requested
        logic                        ref_o;    // registered ref tick
        logic                        fb_o;     // registered feedback tick
        logic                        sys_o;    // registered system tick
        logic                        on_pll;   // registered selector
    } ncocd_top_s;

    ncocd_top_s r;
    ncocd_top_s next_r;
    logic       xtal_tick;
    logic       vco_tick;

    ncocd_nco_if pre_if ();
    ncocd_nco_if fb_if ();

    // rising edges of the synced pins become mclk enables
    assign xtal_tick = r.xs[1] & ~r.xprev;
    assign vco_tick  = r.vs[1] & ~r.vprev;

    // prescaler: 5-bit divisor widened into the shared nco
    assign pre_if.divisor = {2'h0, pre_divisor};                      // RULE1
    assign pre_if.seq_len = pre_seq_len;                              // RULE1
    assign pre_if.pattern = pre_pattern;                              // RULE1
    assign pre_if.restart = div_write;                                // RULE17
    assign pre_if.in_tick = xtal_tick;

    // feedback divider counts vco edges
    assign fb_if.divisor = fb_divisor;                                // RULE5
    assign fb_if.seq_len = fb_seq_len;                                // RULE5
    assign fb_if.pattern = fb_pattern;                                // RULE5
    assign fb_if.restart = div_write;                                 // RULE17
    assign fb_if.in_tick = vco_tick;

    ncocd_nco u_pre (
        .mclk (mclk),
        .rstn (rstn),
        .bus  (pre_if)
    );

    ncocd_nco u_fb (
        .mclk (mclk),
        .rstn (rstn),
        .bus  (fb_if)                                                 // RULE6
    );

    // synchronisers, divide by nine, pump control and the switch sequencer
    always_comb begin
        next_r = r;
        next_r.xs    = {r.xs[0], xtal_clk_pin};
        next_r.vs    = {r.vs[0], vco_clk_pin};
        next_r.ls    = {r.ls[0], pll_lock_indicator};
        next_r.xprev = r.xs[1];
        next_r.vprev = r.vs[1];
        next_r.ref_o = pre_if.out_tick;
        next_r.fb_o  = fb_if.out_tick;

        // crystal divided by nine is the reset clock source
        if (xtal_tick) begin
            next_r.xcnt = (r.xcnt == ncocd_pkg::XDIV_LAST) ? 4'h0 : r.xcnt + 4'h1; // RULE12
        end

        // new settings raise pump current; lock or force ends it, a fresh write wins
        if (r.ls[1] || force_vco) begin
            next_r.pump = 1'b0;                                       // RULE8 RULE9
        end
        if (div_write) begin
            next_r.pump = 1'b1;                                       // RULE8
        end

        // a request made early is held until the frame sync wait has run
        if (switch_write) begin
            next_r.sw_req = 1'b1;                                     // RULE11
        end

        case (r.st)
            ncocd_pkg::NCOCD_XTAL: begin
                if (last_write) begin
                    next_r.fs_cnt = 2'h0;
                    next_r.st     = ncocd_pkg::NCOCD_WAIT;
                end
            end
            ncocd_pkg::NCOCD_WAIT: begin
                if (last_write) begin
                    next_r.fs_cnt = 2'h0;                             // RULE13
                end else if (frame_sync && r.fs_cnt != ncocd_pkg::FS_NEEDED) begin
                    next_r.fs_cnt = r.fs_cnt + 2'h1;                  // RULE13
                end
                // leave the crystal source only at the end of a full crystal period
                if (r.fs_cnt == ncocd_pkg::FS_NEEDED && (r.sw_req || switch_write)
                        && !last_write && xtal_tick && r.xcnt == ncocd_pkg::XDIV_LAST) begin
                    next_r.st = ncocd_pkg::NCOCD_GAP;                 // RULE13 RULE14
                end
            end
            ncocd_pkg::NCOCD_GAP: begin
                // idle gap, then join the pll on its next whole period
                if (vco_tick) begin
                    next_r.st     = ncocd_pkg::NCOCD_PLL;             // RULE14
                    next_r.on_pll = 1'b1;                             // RULE11
                end
            end
            ncocd_pkg::NCOCD_PLL: begin
                next_r.on_pll = 1'b1;
            end
            default: begin
                next_r.st = ncocd_pkg::NCOCD_XTAL;
            end
        endcase

        // exactly one source feeds the tick, and nothing during the gap
        next_r.sys_o = 1'b0;
        if (r.st == ncocd_pkg::NCOCD_PLL) begin
            next_r.sys_o = vco_tick;                                  // RULE14
        end else if (r.st != ncocd_pkg::NCOCD_GAP) begin
            next_r.sys_o = xtal_tick && r.xcnt == ncocd_pkg::XDIV_LAST; // RULE12
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r      <= '0;
            r.pump <= 1'b1;
            r.st   <= ncocd_pkg::NCOCD_XTAL;
        end else begin
            r <= next_r;
        end
    end

    assign ref_tick   = r.ref_o;
    assign fb_tick    = r.fb_o;
    assign pump_high  = r.pump;
    assign sys_tick   = r.sys_o;
    assign sys_on_pll = r.on_pll;
endmodule

// >>> ncocd_sva.sv
// checker for the nco divider and clock switch top
// assumes it is bound onto ncocd_top, all in the mclk domain
`timescale 1ns/10ps
module ncocd_sva (
    input wire logic mclk,               // clock
    input wire logic rstn,               // reset, low
    input wire logic div_write,          // set write
    input wire logic last_write,         // 0Dh write
    input wire logic switch_write,       // 0Eh write
    input wire logic frame_sync,         // frame pulse
    input wire logic pll_lock_indicator, // lock
    input wire logic force_vco,          // force bit
    input wire logic ref_tick,           // ref period
    input wire logic fb_tick,            // fb period
    input wire logic pump_high,          // pump level
    input wire logic sys_tick,           // sys period
    input wire logic sys_on_pll          // pll chosen
);
    logic [1:0] fs;  // frame syncs since 0Dh
    logic       req; // 0Eh seen
    // mirror of the switch preconditions, saturating at two
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fs  <= 2'h0;
            req <= 1'b0;
        end else begin
            if (last_write) fs <= 2'h0;
            else if (frame_sync && fs != 2'h2) fs <= fs + 2'h1;
            req <= req | switch_write;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_quiet; !sys_tick [*2]; endsequence
    // spacing limits come from the fastest legal pin edges, so runts show up here
    property p_pump_set; div_write |=> pump_high; endproperty
    a_pump_set: assert property (p_pump_set) else $error("pump not raised");
    property p_pump_frc; force_vco && !div_write |=> !pump_high; endproperty
    a_pump_frc: assert property (p_pump_frc) else $error("pump kept high");
    // lock pin passes two sync flops before it can clear the pump flag
    property p_pump_fall;
        $fell(pump_high) |-> $past(force_vco) || $past(pll_lock_indicator, 3);
    endproperty
    a_pump_fall: assert property (p_pump_fall) else $error("pump dropped early");
    property p_late; $rose(sys_on_pll) |-> fs == 2'h2 && req; endproperty
    a_late: assert property (p_late) else $error("switch too early");
    property p_hold; !req |-> !sys_on_pll; endproperty
    a_hold: assert property (p_hold) else $error("switch not commanded");
    property p_sticky; sys_on_pll |=> sys_on_pll; endproperty
    a_sticky: assert property (p_sticky) else $error("switch undone");
    // a crystal-side tick, the last one before the switch too, is followed by a quiet gap
    property p_no_runt; sys_tick && !sys_on_pll |=> s_quiet; endproperty
    a_no_runt: assert property (p_no_runt) else $error("runt system tick");
    property p_ref_gap; ref_tick |=> !ref_tick [*3]; endproperty
    a_ref_gap: assert property (p_ref_gap) else $error("ref ticks too close");
    property p_fb_gap; fb_tick |=> !fb_tick [*5]; endproperty
    a_fb_gap: assert property (p_fb_gap) else $error("fb ticks too close");
endmodule
bind ncocd_top ncocd_sva u_sva (.mclk, .rstn, .div_write, .last_write, .switch_write,
    .frame_sync, .pll_lock_indicator, .force_vco, .ref_tick, .fb_tick, .pump_high,
    .sys_tick, .sys_on_pll);

// >>> ncocd_host.sv
// host model: programs divider sets and requests the clock switch
// assumes the bench calls its tasks; drives just after falling mclk
`timescale 1ns/10ps
module ncocd_host (
    input wire logic mclk,         // clock
    output logic [4:0] pre_divisor,  // 08h field
    output logic [2:0] pre_seq_len,  // length
    output logic [7:0] pre_pattern,  // pattern
    output logic [6:0] fb_divisor,   // fb divisor
    output logic [2:0] fb_seq_len,   // fb length
    output logic [7:0] fb_pattern,   // fb pattern
    output logic       div_write,    // set strobe
    output logic       last_write,   // 0Dh strobe
    output logic       switch_write  // 0Eh strobe
);
    // nonzero divisors so nothing odd runs before the first set
    initial {pre_divisor, pre_seq_len, pre_pattern} = {5'h02, 11'h000};
    initial {fb_divisor, fb_seq_len, fb_pattern} = {7'h02, 11'h000};
    initial {div_write, last_write, switch_write} = 3'h0;
    // six register strobes in ascending order, 0Dh last
    task automatic wr_set(input logic [33:0] v);
        for (int r = 0; r < 6; r++) begin
            @(negedge mclk);
            if (r == 0) {pre_divisor, pre_seq_len, pre_pattern} = v[33:18];
            if (r == 3) {fb_divisor, fb_seq_len, fb_pattern} = v[17:0];
            div_write = 1'b1;
            last_write = (r == 5);
            @(negedge mclk);
            {div_write, last_write} = 2'h0;
        end
    endtask
    // clock switch command, may come before the frame syncs
    task automatic req_switch();
        @(negedge mclk);
        switch_write = 1'b1;
        @(negedge mclk);
        switch_write = 1'b0;
    endtask
endmodule

// >>> tb_nco_clock_divider_switch.sv
// self-checking bench for the nco divider and clock switch
// assumes host model and checker are compiled before it
`timescale 1ns/10ps
module tb_nco_clock_divider_switch;
    logic [4:0]  pre_divisor;
    logic [2:0]  pre_seq_len, fb_seq_len;
    logic [7:0]  pre_pattern, fb_pattern;
    logic [6:0]  fb_divisor;
    logic        div_write, last_write, switch_write, ref_tick, fb_tick;
    logic        pump_high, sys_tick, sys_on_pll, frame_sync = 0, force_vco = 0;
    logic        mclk = 0, rstn = 0, xtal_clk_pin = 0, vco_clk_pin = 0, pll_lock_indicator = 0;
    logic [33:0] v;
    logic [31:0] seed = 32'h0000F2DD;
    int          xe, ve, rk, fk, sl, cyc, fails, total_checks, rq = 99999, sm = -1;
    int          rlv, flv, ex;  // edge counts at the last counted tick, expected length
    ncocd_host u_host (.mclk, .pre_divisor, .pre_seq_len, .pre_pattern, .fb_divisor,
        .fb_seq_len, .fb_pattern, .div_write, .last_write, .switch_write);
    ncocd_top DUT (.mclk, .rstn, .xtal_clk_pin, .vco_clk_pin, .pre_divisor, .pre_seq_len,
        .pre_pattern, .fb_divisor, .fb_seq_len, .fb_pattern, .div_write, .last_write,
        .switch_write, .frame_sync, .pll_lock_indicator, .force_vco, .ref_tick, .fb_tick,
        .pump_high, .sys_tick, .sys_on_pll);
    always #25 mclk = ~mclk;
    always @(posedge xtal_clk_pin) xe++;
    always @(posedge vco_clk_pin) ve++;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // input edges in output period k, highest used pattern bit first
    function automatic int exp_len(input logic [6:0] d, input logic [2:0] l,
                                   input logic [7:0] p, input int k);
        return d + ((l != 3'h0) ? p[l - k % (l + 1)] : 0);
    endfunction
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic frame();
        frame_sync = 1'b1;
        @(negedge mclk);
        frame_sync = 1'b0;
    endtask
    // a write restarts the period count; ticks already in flight are ignored
    always @(posedge mclk) begin
        if (rq > 0) rq--;
        if (div_write) {rq, rk, fk} = {32'd6, 64'd0};
    end
    // pins move off the sampling edge so edge-to-tick latency is fixed
    always @(negedge mclk) begin
        cyc++;
        if (cyc % 2 == 0) xtal_clk_pin <= ~xtal_clk_pin;
        if (cyc % 3 == 0) vco_clk_pin <= ~vco_clk_pin;
        // the first tick after a write only marks the start, so the old set never leaks in
        if (ref_tick && rq == 0) begin
            ex = exp_len(pre_divisor, pre_seq_len, pre_pattern, rk);
            if (rk > 0) chk(ex, xe - rlv);
            rlv = xe;
            rk++;
        end
        if (fb_tick && rq == 0) begin
            ex = exp_len(fb_divisor, fb_seq_len, fb_pattern, fk);
            if (fk > 0) chk(ex, ve - flv);
            flv = ve;
            fk++;
        end
        if (sys_tick) begin
            if (sm == int'(sys_on_pll)) chk(sys_on_pll ? 1 : 9, (sys_on_pll ? ve : xe) - sl);
            sl = sys_on_pll ? ve : xe;
            sm = int'(sys_on_pll);
        end
        if (cyc == 90000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (8) @(negedge mclk);
        rstn = 1'b1;
        @(negedge mclk);
        chk(1, pump_high);
        chk(0, sys_on_pll);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            v = {5'(2 + seed[4:0] % 30), seed[7:5], seed[15:8],
                 7'(2 + seed[22:16] % 39), seed[25:23], seed[31:24]};
            if (i == 0) v = {5'h1F, 3'h0, 8'hFF, 7'h7F, 3'h0, 8'hFF};
            if (i == 1) v = {5'h0F, 3'h7, 8'hDA, 7'h13, 3'h4, 8'h01};
            u_host.wr_set(v);
            chk(1, pump_high);
            if (i % 2 == 1) force_vco = 1'b1;
            else pll_lock_indicator = 1'b1;
            wait (rk > 2 * pre_seq_len + 2 && fk > 2 * fb_seq_len + 2);
            @(negedge mclk);
            chk(0, pump_high);
            {force_vco, pll_lock_indicator} = 2'h0;
        end
        u_host.req_switch();
        frame();
        repeat (40) @(negedge mclk);
        chk(0, sys_on_pll);
        frame();
        wait (sys_on_pll === 1'b1);
        repeat (60) @(negedge mclk);
        final_report();
    end
endmodule
